// ### src/link_capability_control_regs.sv
// Link capability and link control registers with an AXI4-Lite slave
//
// Behaviour
// RQ1: Max speed field reads fixed 2.5 Gbps code
// RQ2: Width field resets x8, writable to narrow
// RQ3: Width other than 1,2,4,8 means x1
// RQ4: Power support field reads fixed three
// RQ5: Standby exit latency five separate, three common
// RQ6: Deep sleep exit latency defaults to two
// RQ7: Top byte reports fixed port index
// RQ8: Power control selects none, L0s, L1, both
// RQ9: Power control resets zero, EEPROM may override
// RQ10: Completion boundary bit always reads zero
// RQ11: Link off bit disables link while set
// RQ12: Link off fixed zero on upstream port
// RQ13: Retrain write one sends LTSSM to Recovery
// RQ14: Retrain bit always reads zero
// RQ15: Upstream retrain ignored while unlock clear
// RQ16: Upstream retrain works while unlock set
// RQ17: Shared clock flag, read-write, resets zero
// RQ18: Long sync sends 4096 FTS, one SKP
// RQ19: Reserved bits read zero, ignore writes
// RQ20: Standby latency follows shared clock flag
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "link_regs_params.svh"
module link_capability_control_regs
   import link_regs_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [1:0]  port_strap,
   input  wire logic        register_unlock_bit,
   input  wire logic        eeprom_load,
   input  wire logic [1:0]  eeprom_pm_enable,
   input  wire logic        standby_exit,
   output phy_ctl_t         phy_ctl,
   output ordered_set_t     ordered_sets
);
   logic [7:0]  port_index_reg;
   logic [5:0]  max_width_reg;
   logic [2:0]  deep_sleep_lat_reg;
   logic [1:0]  pm_enable_reg;
   logic        link_off_reg;
   logic        shared_refclk_reg;
   logic        long_sync_reg;
   logic        wr_en;
   logic        rd_en;
   logic [31:0] wmask;
   logic [31:0] wval;
   logic [31:0] cap_value;
   logic [31:0] ctl_value;
   logic [11:0] rd_addr_reg;
   logic        upstream;
   logic        retrain_ok;

   // Strap sampled while reset is held; index fixed for the whole session
   always_ff @(posedge clk) begin
      if (rst) begin
         port_index_reg <= {6'h00, port_strap}; // [RQ7]
      end
   end

   assign upstream   = port_index_reg[1:0] == `UPSTREAM_PORT;
   assign retrain_ok = !upstream || register_unlock_bit; // [RQ15] [RQ16]

   // Bus slave: address and data taken together, one write and one read open
   assign wr_en = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
   assign rd_en = s_axi_arready && s_axi_arvalid;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmask[8*i +: 8] = {8{s_axi_wstrb[i]}};
      end
   end
   assign wval = s_axi_wdata & wmask;

   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
      end else if (wr_en) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b1;
         s_axi_bresp   <= (s_axi_awaddr == `LCAP_OFFSET || s_axi_awaddr == `LCTL_OFFSET)
                          ? `RESP_OKAY : `RESP_SLVERR;
      end else begin
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `RESP_OKAY;
         rd_addr_reg   <= 12'h000;
      end else if (rd_en) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         rd_addr_reg   <= s_axi_araddr;
         s_axi_rresp   <= `RESP_OKAY;
         if (s_axi_araddr == `LCAP_OFFSET) begin
            s_axi_rdata <= cap_value;
         end else if (s_axi_araddr == `LCTL_OFFSET) begin
            s_axi_rdata <= ctl_value;
         end else begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_SLVERR;
         end
      end else begin
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
         end
      end
   end

   // Read images; reserved bits and retrain bit always zero
   assign cap_value = {port_index_reg,                               // [RQ7]
                       6'h00,                                        // [RQ19]
                       deep_sleep_lat_reg,                           // [RQ6]
                       shared_refclk_reg ? `L0S_LAT_COMMON : `L0S_LAT_SEP, // [RQ5] [RQ20]
                       `PM_SUPPORT,                                  // [RQ4]
                       max_width_reg,                                // [RQ2]
                       `SPEED_2G5};                                  // [RQ1]
   assign ctl_value = {16'h0000, 8'h00, long_sync_reg, shared_refclk_reg,
                       1'b0, link_off_reg, 1'b0, 1'b0, pm_enable_reg}; // [RQ10] [RQ14] [RQ19]

   // Capability writable fields
   always_ff @(posedge clk) begin
      if (rst) begin
         max_width_reg      <= `WIDTH_RESET; // [RQ2]
         deep_sleep_lat_reg <= `L1_LAT_RESET; // [RQ6]
      end else if (wr_en && s_axi_awaddr == `LCAP_OFFSET) begin
         if (s_axi_wstrb[0] && s_axi_wstrb[1]) begin
            max_width_reg <= wval[`CAP_WIDTH_MSB:`CAP_WIDTH_LSB];
         end
         if (s_axi_wstrb[1] && s_axi_wstrb[2]) begin
            deep_sleep_lat_reg <= wval[`CAP_L1_MSB:`CAP_L1_LSB];
         end
      end
   end

   // Control fields; EEPROM load may replace the power control default
   always_ff @(posedge clk) begin
      if (rst) begin
         pm_enable_reg     <= `PM_CTL_RESET; // [RQ9]
         link_off_reg      <= 1'b0;
         shared_refclk_reg <= 1'b0; // [RQ17]
         long_sync_reg     <= 1'b0;
      end else if (wr_en && s_axi_awaddr == `LCTL_OFFSET && s_axi_wstrb[0]) begin
         pm_enable_reg     <= s_axi_wdata[1:0]; // [RQ8]
         link_off_reg      <= s_axi_wdata[`CTL_LINK_OFF] && !upstream; // [RQ12]
         shared_refclk_reg <= s_axi_wdata[`CTL_SHARED_CLK]; // [RQ17]
         long_sync_reg     <= s_axi_wdata[`CTL_LONG_SYNC];
      end else if (eeprom_load) begin
         pm_enable_reg <= eeprom_pm_enable; // [RQ9]
      end
   end

   // Physical layer controls, each from a flip-flop
   always_ff @(posedge clk) begin
      if (rst) begin
         phy_ctl <= '{pm_enable: `PM_CTL_RESET, lane_width: 4'h1, default: 1'b0};
      end else begin
         phy_ctl.pm_enable     <= pm_enable_reg; // [RQ8]
         phy_ctl.link_off      <= link_off_reg; // [RQ11]
         phy_ctl.shared_refclk <= shared_refclk_reg;
         phy_ctl.long_sync     <= long_sync_reg;
         phy_ctl.retrain       <= wr_en && s_axi_awaddr == `LCTL_OFFSET && s_axi_wstrb[0]
                                  && s_axi_wdata[`CTL_RETRAIN] && retrain_ok; // [RQ13]
         case (max_width_reg)
            6'h01, 6'h02, 6'h04, 6'h08: phy_ctl.lane_width <= max_width_reg[3:0];
            default:                    phy_ctl.lane_width <= 4'h1; // [RQ3]
         endcase
      end
   end

   // Only entered when software allows standby entry
   fts_sequencer u_fts_sequencer (
      .clk        (clk),
      .rst        (rst),
      .exit_start (standby_exit && pm_enable_reg[0]),
      .long_sync  (long_sync_reg), // [RQ18]
      .os_out     (ordered_sets)
   );

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_cap_fixed;
      s_axi_rvalid && rd_addr_reg == `LCAP_OFFSET |->
         s_axi_rdata[3:0] == `SPEED_2G5 && s_axi_rdata[11:10] == `PM_SUPPORT
         && s_axi_rdata[23:18] == 6'h00;
   endproperty
   a_cap_fixed: assert property (p_cap_fixed) else $error("Fixed cap fields wrong"); // [RQ1]

   property p_l0s_code;
      s_axi_rvalid && $rose(s_axi_rvalid) && rd_addr_reg == `LCAP_OFFSET |->
         s_axi_rdata[14:12] == ($past(shared_refclk_reg) ? `L0S_LAT_COMMON : `L0S_LAT_SEP);
   endproperty
   a_l0s_code: assert property (p_l0s_code) else $error("Standby latency wrong"); // [RQ5]

   property p_ctl_zero_bits;
      s_axi_rvalid && rd_addr_reg == `LCTL_OFFSET |->
         s_axi_rdata[5] == 1'b0 && s_axi_rdata[3:2] == 2'b00 && s_axi_rdata[31:8] == 24'h0;
   endproperty
   a_ctl_zero_bits: assert property (p_ctl_zero_bits) else $error("Zero bits set"); // [RQ14]

   property p_width_fallback;
      !(max_width_reg inside {6'h01, 6'h02, 6'h04, 6'h08}) |=> phy_ctl.lane_width == 4'h1;
   endproperty
   a_width_fallback: assert property (p_width_fallback) else $error("Bad width"); // [RQ3]

   property p_upstream_off;
      upstream |-> !link_off_reg && !phy_ctl.link_off;
   endproperty
   a_upstream_off: assert property (p_upstream_off) else $error("Upstream link off"); // [RQ12]

   property p_retrain_locked;
      upstream && !register_unlock_bit |=> !phy_ctl.retrain;
   endproperty
   a_retrain_locked: assert property (p_retrain_locked) else $error("Locked retrain"); // [RQ15]

   property p_retrain_go;
      wr_en && s_axi_awaddr == `LCTL_OFFSET && s_axi_wstrb[0] && s_axi_wdata[5]
         && retrain_ok |=> phy_ctl.retrain ##1 !phy_ctl.retrain;
   endproperty
   a_retrain_go: assert property (p_retrain_go) else $error("Retrain pulse wrong"); // [RQ13]

   property p_link_off_follow;
      link_off_reg |=> phy_ctl.link_off;
   endproperty
   a_link_off_follow: assert property (p_link_off_follow) else $error("Link off lost"); // [RQ11]

   property p_pm_follow;
      ##1 phy_ctl.pm_enable == $past(pm_enable_reg);
   endproperty
   a_pm_follow: assert property (p_pm_follow) else $error("Power control lost"); // [RQ8]

   property p_bresp_after_write;
      wr_en |=> s_axi_bvalid;
   endproperty
   a_bresp_after_write: assert property (p_bresp_after_write) else $error("No write resp");

   property p_reset_defaults;
      $fell(rst) |-> max_width_reg == `WIDTH_RESET && deep_sleep_lat_reg == `L1_LAT_RESET
         && pm_enable_reg == `PM_CTL_RESET && !link_off_reg && !shared_refclk_reg
         && !long_sync_reg && phy_ctl.lane_width == 4'h1 && ordered_sets == '0;
   endproperty
   a_reset_defaults: assert property (p_reset_defaults) else $error("Bad reset values"); // [RQ6]

   logic [5:0] width_wdata;
   assign width_wdata = s_axi_wdata[`CAP_WIDTH_MSB:`CAP_WIDTH_LSB];
   property p_width_write;
      wr_en && s_axi_awaddr == `LCAP_OFFSET && s_axi_wstrb[1:0] == 2'b11 |=>
         max_width_reg == $past(width_wdata);
   endproperty
   a_width_write: assert property (p_width_write) else $error("Width not written"); // [RQ2]

   property p_width_kept;
      wr_en && !s_axi_wstrb[0] |=> $stable(max_width_reg);
   endproperty
   a_width_kept: assert property (p_width_kept) else $error("Width lane ignored"); // [RQ2]

   property p_lane_legal;
      phy_ctl.lane_width inside {4'h1, 4'h2, 4'h4, 4'h8};
   endproperty
   a_lane_legal: assert property (p_lane_legal) else $error("Lane width illegal"); // [RQ3]

   property p_ctl_image;
      $rose(s_axi_rvalid) && rd_addr_reg == `LCTL_OFFSET |-> s_axi_rdata[7:0] ==
         {$past(long_sync_reg), $past(shared_refclk_reg), 1'b0, $past(link_off_reg),
          2'b00, $past(pm_enable_reg)};
   endproperty
   a_ctl_image: assert property (p_ctl_image) else $error("Control image wrong"); // [RQ17]

   property p_eeprom_load;
      eeprom_load && !(wr_en && s_axi_awaddr == `LCTL_OFFSET && s_axi_wstrb[0]) |=>
         pm_enable_reg == $past(eeprom_pm_enable);
   endproperty
   a_eeprom_load: assert property (p_eeprom_load) else $error("EEPROM value lost"); // [RQ9]

   property p_port_fixed;
      !$fell(rst) |-> $stable(port_index_reg);
   endproperty
   a_port_fixed: assert property (p_port_fixed) else $error("Port index moved"); // [RQ7]

   property p_link_off_clear;
      !link_off_reg |=> !phy_ctl.link_off;
   endproperty
   a_link_off_clear: assert property (p_link_off_clear) else $error("Link off stuck"); // [RQ11]

   property p_flags_follow;
      1'b1 |=> phy_ctl.shared_refclk == $past(shared_refclk_reg)
         && phy_ctl.long_sync == $past(long_sync_reg);
   endproperty
   a_flags_follow: assert property (p_flags_follow) else $error("Clock flags lost"); // [RQ17]

   property p_standby_gate;
      standby_exit && !pm_enable_reg[0] && !ordered_sets.busy |=> !ordered_sets.busy;
   endproperty
   a_standby_gate: assert property (p_standby_gate) else $error("Burst without L0s"); // [RQ8]

   property p_one_write;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_one_write: assert property (p_one_write) else $error("Write taken during response");

   property p_one_read;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_one_read: assert property (p_one_read) else $error("Read taken during response");

   property p_ar_pulse;
      rd_en |=> !s_axi_arready && s_axi_rvalid;
   endproperty
   a_ar_pulse: assert property (p_ar_pulse) else $error("Read response missing");

   property p_bresp_code;
      wr_en && s_axi_awaddr != `LCAP_OFFSET && s_axi_awaddr != `LCTL_OFFSET |=>
         s_axi_bresp == `RESP_SLVERR;
   endproperty
   a_bresp_code: assert property (p_bresp_code) else $error("Unmapped write accepted");

   c_retrain:   cover property (phy_ctl.retrain);
   c_link_off:  cover property (phy_ctl.link_off);
   c_narrow:    cover property (phy_ctl.lane_width == 4'h2);
   c_unmapped:  cover property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR);
endmodule : link_capability_control_regs
`default_nettype wire

// ### src/link_regs_params.svh
// Offsets, field positions, reset values and counts of the link register pair
`ifndef LINK_REGS_PARAMS_SVH
`define LINK_REGS_PARAMS_SVH
`define LCAP_OFFSET      12'h04c
`define LCTL_OFFSET      12'h050
`define SPEED_2G5        4'h1
`define WIDTH_RESET      6'h08
`define PM_SUPPORT       2'h3
`define L0S_LAT_SEP      3'h5
`define L0S_LAT_COMMON   3'h3
`define L1_LAT_RESET     3'h2
`define PM_CTL_RESET     2'h0
`define UPSTREAM_PORT    2'h0
`define CAP_WIDTH_LSB    4
`define CAP_WIDTH_MSB    9
`define CAP_L1_LSB       15
`define CAP_L1_MSB       17
`define CTL_LINK_OFF     4
`define CTL_RETRAIN      5
`define CTL_SHARED_CLK   6
`define CTL_LONG_SYNC    7
`define LONG_FTS_COUNT   13'h1000
`define SHORT_FTS_COUNT  13'h0020
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

// ### src/link_regs_pkg.sv
// Types shared by the link capability and control register block
package link_regs_pkg;
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_FTS  = 2'b01,
      SEQ_SKP  = 2'b10
   } seq_state_t;

   typedef struct packed {
      logic [1:0] pm_enable;
      logic       link_off;
      logic       retrain;
      logic       shared_refclk;
      logic       long_sync;
      logic [3:0] lane_width;
   } phy_ctl_t;

   typedef struct packed {
      logic send_fts;
      logic send_skp;
      logic busy;
   } ordered_set_t;
endpackage : link_regs_pkg

// ### src/fts_sequencer.sv
// Ordered set sequencer for leaving the standby low-power state
`timescale 1ns/10ps
`default_nettype none
`include "link_regs_params.svh"
module fts_sequencer
   import link_regs_pkg::*;
(
   input  wire logic   clk,
   input  wire logic   rst,
   input  wire logic   exit_start,
   input  wire logic   long_sync,
   output ordered_set_t os_out
);
   seq_state_t  state_reg;
   logic [12:0] count_reg;
   logic        skp_after_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg     <= SEQ_IDLE;
         count_reg     <= 13'h0000;
         skp_after_reg <= 1'b0;
         os_out        <= '0;
      end else begin
         case (state_reg)
            SEQ_IDLE: begin
               os_out <= '0;
               if (exit_start) begin
                  // Long mode latched at start so a mid-burst change is harmless
                  count_reg     <= long_sync ? `LONG_FTS_COUNT : `SHORT_FTS_COUNT; // [RQ18]
                  skp_after_reg <= long_sync;
                  state_reg     <= SEQ_FTS;
                  os_out        <= '{send_fts: 1'b1, send_skp: 1'b0, busy: 1'b1};
               end
            end
            SEQ_FTS: begin
               if (count_reg == 13'h0001) begin
                  state_reg <= skp_after_reg ? SEQ_SKP : SEQ_IDLE;
                  os_out    <= '{send_fts: 1'b0, send_skp: skp_after_reg,
                                 busy: skp_after_reg}; // [RQ18]
               end
               count_reg <= count_reg - 13'h0001;
            end
            SEQ_SKP: begin
               state_reg <= SEQ_IDLE;
               os_out    <= '0;
            end
            default: begin
               state_reg <= SEQ_IDLE;
               os_out    <= '0;
            end
         endcase
      end
   end

   // Counts FTS pulses of the current burst
   logic [12:0] fts_seen_reg;
   always_ff @(posedge clk) begin
      if (rst || state_reg == SEQ_IDLE) begin
         fts_seen_reg <= 13'h0000;
      end else if (os_out.send_fts) begin
         fts_seen_reg <= fts_seen_reg + 13'h0001;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_long_burst;
      os_out.send_skp |-> fts_seen_reg == `LONG_FTS_COUNT && !os_out.send_fts;
   endproperty
   a_long_burst: assert property (p_long_burst) else $error("SKP not after 4096 FTS"); // [RQ18]

   c_long_exit: cover property (os_out.send_skp);
endmodule : fts_sequencer
`default_nettype wire

// ### verif/tb_top.sv
// Self-checking bench for the link capability and control registers
`timescale 1ns/10ps
`default_nettype none
`include "link_regs_params.svh"
module tb_top;
   import link_regs_pkg::*;
   logic         clk;
   logic         rst;
   logic [11:0]  awaddr;
   logic         awvalid;
   logic         awready;
   logic [31:0]  wdata;
   logic [3:0]   wstrb;
   logic         wvalid;
   logic         wready;
   logic [1:0]   bresp;
   logic         bvalid;
   logic         bready;
   logic [11:0]  araddr;
   logic         arvalid;
   logic         arready;
   logic [31:0]  rdata;
   logic [1:0]   rresp;
   logic         rvalid;
   logic         rready;
   logic [1:0]   port_strap;
   logic         unlock;
   logic         eeprom_load;
   logic [1:0]   eeprom_pm;
   logic         standby_exit;
   phy_ctl_t     phy_ctl;
   ordered_set_t ordered_sets;
   int           n_errors;
   int           cmp_count;
   int           n_fts;
   int           n_skp;
   int           n_ret;
   logic [1:0]   rsp;
   logic [31:0]  rd;
   logic [5:0]   widths [7] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h03, 6'h00, 6'h10};

   link_capability_control_regs dut (
      .clk(clk), .rst(rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .port_strap(port_strap), .register_unlock_bit(unlock),
      .eeprom_load(eeprom_load), .eeprom_pm_enable(eeprom_pm),
      .standby_exit(standby_exit), .phy_ctl(phy_ctl), .ordered_sets(ordered_sets));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Sampled mid-cycle so registered pulses are never raced
   always @(negedge clk) begin
      if (ordered_sets.send_fts === 1'b1) n_fts++;
      if (ordered_sets.send_skp === 1'b1) n_skp++;
      if (phy_ctl.retrain === 1'b1) n_ret++;
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", name, exp, got);
         n_errors++;
      end
   endtask : chk

   task automatic final_report;
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : final_report

   // Ready is looked at mid-cycle, the request dropped after the taking edge
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      @(negedge clk);
      while (awready !== 1'b1) @(negedge clk);
      @(posedge clk);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      @(negedge clk);
      while (bvalid !== 1'b1) @(negedge clk);
      rsp = bresp;
      @(posedge clk);
      bready <= 1'b0;
   endtask : axi_write

   task automatic axi_read(input logic [11:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      @(negedge clk);
      while (arready !== 1'b1) @(negedge clk);
      @(posedge clk);
      arvalid <= 1'b0;
      @(negedge clk);
      while (rvalid !== 1'b1) @(negedge clk);
      rd = rdata;
      rsp = rresp;
      @(posedge clk);
      rready <= 1'b0;
   endtask : axi_read

   task automatic do_reset(input logic [1:0] strap);
      @(posedge clk);
      rst <= 1'b1;
      port_strap <= strap;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : do_reset

   // Bursts are timed by the busy flag, not by an assumed length
   task automatic standby_burst(input int fts, input int skp);
      n_fts = 0;
      n_skp = 0;
      @(posedge clk);
      standby_exit <= 1'b1;
      @(posedge clk);
      standby_exit <= 1'b0;
      repeat (2) @(negedge clk);
      while (ordered_sets.busy === 1'b1) @(negedge clk);
      repeat (2) @(negedge clk);
      chk("fts_count", fts, n_fts);
      chk("skp_count", skp, n_skp);
   endtask : standby_burst

   function automatic logic [31:0] cap_word(logic [5:0] w, logic [2:0] l0s, logic [2:0] l1,
                                            logic [7:0] port);
      return {port, 6'h00, l1, l0s, 2'h3, w, 4'h1};
   endfunction : cap_word

   initial begin
      rst = 1'b1;
      awaddr = 12'h000; awvalid = 1'b0; wdata = 32'h0; wvalid = 1'b0; bready = 1'b0;
      araddr = 12'h000; arvalid = 1'b0; rready = 1'b0; port_strap = 2'h1; unlock = 1'b0;
      eeprom_load = 1'b0; eeprom_pm = 2'h0; standby_exit = 1'b0;
      wstrb = 4'hf;
      n_errors = 0; cmp_count = 0; n_fts = 0; n_skp = 0; n_ret = 0;
      do_reset(2'h1);
      axi_read(12'h04c);
      chk("cap_reset", cap_word(6'h08, 3'h5, 3'h2, 8'h01), rd);
      axi_read(12'h050);
      chk("ctl_reset", 32'h0, rd);
      chk("lane_reset", 32'h8, {28'h0, phy_ctl.lane_width});
      axi_write(12'h050, 32'hffff_ffff);
      repeat (2) @(negedge clk);
      chk("retrain_pulse", 32'h1, n_ret);
      chk("link_off", 32'h1, {31'h0, phy_ctl.link_off});
      chk("shared_clk", 32'h1, {31'h0, phy_ctl.shared_refclk});
      axi_read(12'h050);
      chk("ctl_all_ones", 32'h0000_00d3, rd);
      axi_read(12'h04c);
      chk("cap_common_clk", cap_word(6'h08, 3'h3, 3'h2, 8'h01), rd);
      standby_burst(4096, 1);
      for (int m = 0; m < 4; m++) begin
         axi_write(12'h050, m);
         axi_read(12'h050);
         chk("pm_read", m, rd);
         chk("pm_out", m, {30'h0, phy_ctl.pm_enable});
      end
      chk("link_off_clear", 32'h0, {31'h0, phy_ctl.link_off});
      axi_write(12'h050, 32'h0000_0001);
      standby_burst(32, 0);
      foreach (widths[k]) begin
         axi_write(12'h04c, {8'hff, 6'h3f, 3'h6, 3'h7, 2'h0, widths[k], 4'h0});
         axi_read(12'h04c);
         chk("cap_write", cap_word(widths[k], 3'h5, 3'h6, 8'h01), rd);
         repeat (2) @(negedge clk);
         chk("lane_width", (widths[k] inside {1, 2, 4, 8}) ? widths[k] : 1,
             {28'h0, phy_ctl.lane_width});
      end
      @(posedge clk);
      wstrb <= 4'h6;
      axi_write(12'h04c, {8'h00, 6'h00, 3'h1, 3'h0, 2'h0, 6'h02, 4'h0});
      wstrb <= 4'hf;
      axi_read(12'h04c);
      chk("cap_lane_strobe", cap_word(6'h10, 3'h5, 3'h1, 8'h01), rd);
      @(posedge clk);
      eeprom_pm <= 2'h2;
      eeprom_load <= 1'b1;
      @(posedge clk);
      eeprom_load <= 1'b0;
      axi_read(12'h050);
      chk("eeprom_pm", 32'h2, rd);
      standby_burst(0, 0);
      axi_write(12'h100, 32'hffff_ffff);
      chk("unmapped_bresp", `RESP_SLVERR, rsp);
      axi_read(12'h100);
      chk("unmapped_rresp", `RESP_SLVERR, rsp);
      chk("unmapped_rdata", 32'h0, rd);
      do_reset(2'h0);
      axi_read(12'h04c);
      chk("cap_upstream", cap_word(6'h08, 3'h5, 3'h2, 8'h00), rd);
      n_ret = 0;
      axi_write(12'h050, 32'h0000_0030);
      axi_read(12'h050);
      chk("upstream_ctl", 32'h0, rd);
      chk("retrain_locked", 32'h0, n_ret);
      unlock <= 1'b1;
      axi_write(12'h050, 32'h0000_0020);
      repeat (2) @(negedge clk);
      chk("retrain_unlocked", 32'h1, n_ret);
      final_report();
   end

   // About 4400 cycles of tests; 20000 cycles means a hang
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      final_report();
   end
endmodule : tb_top
`default_nettype wire
